/* File: hdl/smp_regs.vh */
`ifndef SMP_REGS_VH
`define SMP_REGS_VH

// Register byte offsets on the APB
`define SMP_CTRL_OFS 8'h00
`define SMP_STAT_OFS 8'h04
`define SMP_DATA_OFS 8'h08

// Control register fields
`define SMP_CTL_SPR_LO 0
`define SMP_CTL_SPR_HI 1
`define SMP_CTL_CLOCK_PHASE_BIT 2
`define SMP_CTL_CLOCK_POLARITY_BIT 3
`define SMP_CTL_MASTER_SELECT_BIT 4
`define SMP_CTL_DATA_ORDER_BIT 5
`define SMP_CTL_PORT_ENABLE_BIT 6
`define SMP_CTL_SELECT_IGNORE_BIT 7
`define SMP_CTL_IEN 8
`define SMP_CTL_W 9
`define SMP_CTL_RST 9'h000

// Status register fields, write one to clear
`define SMP_STAT_WRITE_COLLISION_FLAG 6
`define SMP_STAT_TRANSFER_COMPLETE_FLAG 7

// Prescaler codes
`define SMP_SPR_DIV4 2'h0
`define SMP_SPR_DIV16 2'h1
`define SMP_SPR_DIV64 2'h2
`define SMP_SPR_DIV128 2'h3

// Half bit period minus one, in pclk cycles
`define SMP_HALF_M1_DIV4 6'h01
`define SMP_HALF_M1_DIV16 6'h07
`define SMP_HALF_M1_DIV64 6'h1F
`define SMP_HALF_M1_DIV128 6'h3F

// Last clock edge index and last bit index of a byte
`define SMP_LAST_EDGE 4'hF
`define SMP_LAST_BIT 4'h7

`endif

/* File: hdl/smp_sync.v */
`timescale 1ns/10ps

// Two-stage synchroniser for pin inputs
module smp_sync #(
	parameter WIDTH = 4
) (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	input wire ce,
	// Asynchronous in, synchronised out
	input wire [WIDTH-1:0] async_in,
	output reg [WIDTH-1:0] sync_q
);

	reg [WIDTH-1:0] meta_q;

	// First stage feeds only the second
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= {WIDTH{1'b1}};
			sync_q <= {WIDTH{1'b1}};
		end else if (ce) begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

endmodule

/* File: hdl/smp_port.v */
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`include "smp_regs.vh"

// Behaviour
// - Enable bit low disables port and releases all four pins.
// - Slave drives slave-out only while select is low or ignore is set; otherwise high-Z.
// - Idle master, select high, ignore clear: master-out and clock high-Z.
// - Active master drives master-out and clock push-pull.
// - Select low with ignore clear clears the master bit.
// - Phase 0 slave: data write with select low is a collision.
// - Phase 1 slave allows ignore set or select held low.
// - Enabled master: data write starts clock and transfer.
// - First master-out bit appears half to one bit time later.
// - After a byte, clock stops, complete flag sets, interrupt if enabled.
// - Master and slave shift registers form one 16-bit ring.
// - Select low on master with ignore clear makes it a slave; pins turn around.
// - Forced drop to slave sets the complete flag too.
// - After forced drop, stays slave until software sets master bit.
// - Data write during transfer sets collision flag, write lost.
// - Received byte copied to read buffer; overwritten if unread.
// - Collision flag cleared by writing one.
// - Two-bit prescale field picks serial clock rate.
// - Ignore set: master bit alone picks role, select pin free.
// - Phase 1 drives on leading, samples trailing; polarity sets idle.
// - Order bit 0 shifts MSB first, 1 shifts LSB first.
// - Complete flag cleared by writing one.
module smp_port (
	// Clock, reset, freeze
	input wire pclk,
	input wire presetn,
	input wire ce,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Serial clock pin
	input wire sclk_in,
	output reg sclk_out_q,
	output reg sclk_oe_n_q,
	// Master-out pin
	input wire mosi_in,
	output reg mosi_out_q,
	output reg mosi_oe_n_q,
	// Slave-out pin
	input wire miso_in,
	output reg miso_out_q,
	output reg miso_oe_n_q,
	// Select pin, input only
	input wire ss_n_in,
	// Pin release and interrupt request
	output reg port_released_q,
	output reg irq_q
);

	// Master state codes
	localparam ST_IDLE = 3'b001;
	localparam ST_WAIT = 3'b010;
	localparam ST_RUN = 3'b100;

	reg [`SMP_CTL_W-1:0] ctrl_q;
	reg transfer_complete_flag_q;
	reg write_collision_flag_q;
	reg [7:0] sr_q;
	reg [7:0] rx_q;
	reg [2:0] state_q;
	reg [5:0] div_q;
	reg [3:0] edge_q;
	reg [3:0] bit_q;
	reg sck_p_q;
	reg m_samp_q;
	reg m_fin_q;
	reg [5:0] half_m1;
	reg [31:0] rd_mux;
	reg rd_hit;

	wire [3:0] pin_s;
	wire sck_s = pin_s[3];
	wire mosi_s = pin_s[2];
	wire miso_s = pin_s[1];
	wire ss_n_s = pin_s[0];

	// Pin inputs pass two flops
	smp_sync #(
		.WIDTH(4)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.async_in({sclk_in, mosi_in, miso_in, ss_n_in}),
		.sync_q(pin_s)
	);

	// Control fields
	wire clock_phase_bit = ctrl_q[`SMP_CTL_CLOCK_PHASE_BIT];
	wire clock_polarity_bit = ctrl_q[`SMP_CTL_CLOCK_POLARITY_BIT];
	wire master_select_bit = ctrl_q[`SMP_CTL_MASTER_SELECT_BIT];
	wire data_order_bit = ctrl_q[`SMP_CTL_DATA_ORDER_BIT];
	wire en = ctrl_q[`SMP_CTL_PORT_ENABLE_BIT];
	wire select_ignore_bit = ctrl_q[`SMP_CTL_SELECT_IGNORE_BIT];
	wire ien = ctrl_q[`SMP_CTL_IEN];
	wire [1:0] spr = ctrl_q[`SMP_CTL_SPR_HI:`SMP_CTL_SPR_LO];

	// Role selection
	// enable and master bit
	wire ss_low = ~ss_n_s;
	wire is_master = en & master_select_bit;
	wire forced = is_master & ~select_ignore_bit & ss_low;
	wire slv_sel = en & ~master_select_bit & (select_ignore_bit | ss_low);

	// APB phases
	wire setup = psel & ~penable;
	wire acc_done = psel & penable & pready;
	wire wr_ctrl = acc_done & pwrite & (paddr == `SMP_CTRL_OFS);
	wire wr_stat = acc_done & pwrite & (paddr == `SMP_STAT_OFS);
	wire data_wr = acc_done & pwrite & (paddr == `SMP_DATA_OFS);

	always @* begin
		case (spr)
		`SMP_SPR_DIV4: half_m1 = `SMP_HALF_M1_DIV4;
		`SMP_SPR_DIV16: half_m1 = `SMP_HALF_M1_DIV16;
		`SMP_SPR_DIV64: half_m1 = `SMP_HALF_M1_DIV64;
		default: half_m1 = `SMP_HALF_M1_DIV128;
		endcase
	end

	// Master clock edges
	wire tick = (div_q == half_m1);
	wire m_go = state_q[1] & tick;
	wire m_edge = state_q[2] & tick;
	wire m_lead = m_edge & ~edge_q[0];
	wire m_trail = m_edge & edge_q[0];
	wire m_done = m_edge & (edge_q == `SMP_LAST_EDGE);

	wire s_rise = sck_s & ~sck_p_q;
	wire s_fall = ~sck_s & sck_p_q;
	wire s_lead = slv_sel & (clock_polarity_bit ? s_fall : s_rise);
	wire s_trail = slv_sel & (clock_polarity_bit ? s_rise : s_fall);
	wire lead = is_master ? m_lead : s_lead;
	wire trail = is_master ? m_trail : s_trail;

	// phase picks sample and drive edges
	// Master samples a cycle late: slave-in lags two flops
	wire m_samp_now = clock_phase_bit ? m_trail : m_lead;
	wire s_samp = clock_phase_bit ? s_trail : s_lead;
	wire sample_ev = is_master ? m_samp_q : s_samp;
	wire drive_ev = clock_phase_bit ? lead : trail;

	// shift in what the far end shifts out
	wire in_bit = is_master ? miso_s : mosi_s;
	wire [7:0] sr_shift = data_order_bit ? {in_bit, sr_q[7:1]} : {sr_q[6:0], in_bit};
	wire top = data_order_bit ? sr_q[0] : sr_q[7];

	wire s_done = ~is_master & sample_ev & (bit_q == `SMP_LAST_BIT);
	wire xfer_done = m_fin_q | s_done;

	// phase 0 slave with select low
	wire s_cph0_sel = en & ~master_select_bit & ~clock_phase_bit & ss_low;
	wire s_busy = (bit_q != 4'h0) | s_cph0_sel;
	wire m_busy = ~state_q[0] | m_fin_q;
	wire collide = data_wr & (is_master ? m_busy : s_busy);
	// enabled idle master starts on write
	wire start = data_wr & is_master & ~m_busy & ~forced;

	wire transfer_complete_flag_clr = wr_stat & pwdata[`SMP_STAT_TRANSFER_COMPLETE_FLAG];
	wire write_collision_flag_clr = wr_stat & pwdata[`SMP_STAT_WRITE_COLLISION_FLAG];
	// completion and forced drop set flag
	wire transfer_complete_flag_d = xfer_done | forced | (transfer_complete_flag_q & ~transfer_complete_flag_clr);

	// Read mux and address decode
	always @* begin
		rd_mux = 32'h0000_0000;
		rd_hit = 1'b1;
		case (paddr)
		`SMP_CTRL_OFS: rd_mux[`SMP_CTL_W-1:0] = ctrl_q;
		`SMP_STAT_OFS: begin
			rd_mux[`SMP_STAT_TRANSFER_COMPLETE_FLAG] = transfer_complete_flag_q;
			rd_mux[`SMP_STAT_WRITE_COLLISION_FLAG] = write_collision_flag_q;
		end
		`SMP_DATA_OFS: rd_mux[7:0] = rx_q;
		default: rd_hit = 1'b0;
		endcase
	end

	// APB answer, one cycle after setup
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (ce) begin
			if (setup) begin
				pready <= 1'b1;
				pslverr <= ~rd_hit;
				prdata <= pwrite ? 32'h0000_0000 : rd_mux;
			end else if (acc_done) begin
				pready <= 1'b0;
				pslverr <= 1'b0;
				prdata <= 32'h0000_0000;
			end
		end
	end

	// Control register
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `SMP_CTL_RST;
		end else if (ce) begin
			if (wr_ctrl)
				ctrl_q <= pwdata[`SMP_CTL_W-1:0];
			if (forced)
				ctrl_q[`SMP_CTL_MASTER_SELECT_BIT] <= 1'b0;
		end
	end

	// Status flags, set wins over clear
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			transfer_complete_flag_q <= 1'b0;
			write_collision_flag_q <= 1'b0;
		end else if (ce) begin
			transfer_complete_flag_q <= transfer_complete_flag_d;
			write_collision_flag_q <= collide | (write_collision_flag_q & ~write_collision_flag_clr);
		end
	end

	// Master clock generator
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_IDLE;
			div_q <= 6'h00;
			edge_q <= 4'h0;
			sclk_out_q <= 1'b0;
			m_samp_q <= 1'b0;
			m_fin_q <= 1'b0;
		end else if (ce) begin
			// Late sample and late finish of a master byte
			m_samp_q <= m_samp_now & ~forced;
			m_fin_q <= m_done & ~forced;
			case (state_q)
			ST_IDLE: begin
				div_q <= 6'h00;
				edge_q <= 4'h0;
				sclk_out_q <= clock_polarity_bit;
				if (start)
					state_q <= ST_WAIT;
			end
			ST_WAIT: begin
				div_q <= tick ? 6'h00 : div_q + 6'h01;
				if (tick)
					state_q <= ST_RUN;
			end
			ST_RUN: begin
				div_q <= tick ? 6'h00 : div_q + 6'h01;
				if (tick) begin
					sclk_out_q <= ~sclk_out_q;
					edge_q <= edge_q + 4'h1;
				end
				if (m_done)
					state_q <= ST_IDLE;
			end
			default: state_q <= ST_IDLE;
			endcase
			if (forced | ~is_master) begin
				state_q <= ST_IDLE;
				sclk_out_q <= clock_polarity_bit;
			end
		end
	end

	// Shift register, bit count, read buffer
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sr_q <= 8'h00;
			rx_q <= 8'h00;
			bit_q <= 4'h0;
			sck_p_q <= 1'b1;
		end else if (ce) begin
			sck_p_q <= sck_s;
			if (data_wr & ~collide)
				sr_q <= pwdata[7:0];
			else if (sample_ev)
				sr_q <= sr_shift;
			if (is_master | ~slv_sel)
				bit_q <= 4'h0;
			else if (s_done)
				bit_q <= 4'h0;
			else if (sample_ev)
				bit_q <= bit_q + 4'h1;
			if (m_fin_q)
				rx_q <= sample_ev ? sr_shift : sr_q;
			else if (s_done)
				rx_q <= sr_shift;
			// phase 1: select may stay low
			if (~is_master & slv_sel & ~clock_phase_bit & ss_n_s)
				bit_q <= 4'h0;
		end
	end

	// Pin drivers and enables
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mosi_out_q <= 1'b1;
			miso_out_q <= 1'b1;
			sclk_oe_n_q <= 1'b1;
			mosi_oe_n_q <= 1'b1;
			miso_oe_n_q <= 1'b1;
			port_released_q <= 1'b1;
			irq_q <= 1'b0;
		end else if (ce) begin
			// phase 0 first bit at half bit
			if (is_master & ((m_go & ~clock_phase_bit) | drive_ev))
				mosi_out_q <= top;
			if (~is_master & (drive_ev | (bit_q == 4'h0)))
				miso_out_q <= top;
			sclk_oe_n_q <= ~(is_master & ~forced & (select_ignore_bit | m_busy | start));
			mosi_oe_n_q <= ~(is_master & ~forced & (select_ignore_bit | m_busy | start));
			miso_oe_n_q <= ~slv_sel;
			port_released_q <= ~en;
			irq_q <= transfer_complete_flag_d & ien;
		end
	end

endmodule

/* File: tb/smp_props.sv */
`timescale 1ns/10ps

// Port-level checks on bus answers and pin drive
module smp_props (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	input wire ce,
	// APB
	input wire psel,
	input wire penable,
	input wire [7:0] paddr,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	// Pins
	input wire sclk_out_q,
	input wire sclk_oe_n_q,
	input wire mosi_oe_n_q,
	input wire miso_oe_n_q,
	input wire port_released_q
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_RDY_ONCE: assert property (ce && psel && !penable |=> pready ##1 !pready)
		else $error("pready is not a one-cycle answer");
	AST_BAD_ADDR: assert property (ce && psel && !penable && paddr > 8'h08
		|=> pslverr) else $error("unmapped address not refused");
	AST_ERR_RDY: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	AST_HIGH_ZERO: assert property (pready |-> prdata[31:9] == 23'h0)
		else $error("upper read bits not zero");
	AST_RELEASE: assert property (port_released_q |-> sclk_oe_n_q &&
		mosi_oe_n_q && miso_oe_n_q) else $error("pin driven while off");
	AST_OE_PAIR: assert property (mosi_oe_n_q == sclk_oe_n_q)
		else $error("clock and master-out drive differ");
	AST_NO_FIGHT: assert property (!mosi_oe_n_q |-> miso_oe_n_q)
		else $error("master-out and slave-out both driven");
	AST_HALF_MIN: assert property (!sclk_oe_n_q && $changed(sclk_out_q)
		|=> $stable(sclk_out_q)) else $error("clock half period too short");
endmodule

/* File: tb/smp_peer.sv */
`timescale 1ns/10ps

// Far-side slave, phase 0, polarity 0, MSB first
module smp_peer (
	// Serial lines
	input wire sclk,
	input wire mosi,
	input wire ss_n,
	output wire miso,
	// Byte to send, byte received
	input wire [7:0] tx_byte,
	output reg [7:0] rx_q = 8'h00
);
	reg [7:0] sh_q = 8'h00;
	always @(negedge ss_n) sh_q <= tx_byte;
	always @(posedge sclk) if (!ss_n) rx_q <= {rx_q[6:0], mosi};
	always @(negedge sclk) if (!ss_n) sh_q <= {sh_q[6:0], 1'b0};
	// Released line shows the inverse bit
	assign miso = ss_n ? ~sh_q[7] : sh_q[7];
endmodule

/* File: tb/spi_master_slave_port_tb.sv */
`timescale 1ns/10ps
`include "smp_regs.vh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
	$display("ERROR %s exp %0h got %0h", n, e, g); end end

module spi_master_slave_port_tb;
	reg pclk, presetn, psel, penable, pwrite, ss_n_in, peer_ss_n, perr;
	reg [7:0] paddr, peer_tx;
	reg [31:0] pwdata, rd;
	wire [31:0] prdata;
	wire [7:0] peer_rx;
	wire pready, pslverr, sclk_out_q, sclk_oe_n_q, mosi_out_q, mosi_oe_n_q;
	wire miso_out_q, miso_oe_n_q, port_released_q, irq_q, peer_miso;
	int fails = 0;
	int tests_run = 0;
	// board pulls the clock low for polarity 0
	wire sclk_w = sclk_oe_n_q ? 1'b0 : sclk_out_q;
	wire mosi_w = mosi_oe_n_q ? ~peer_rx[0] : mosi_out_q;
	wire miso_w = miso_oe_n_q ? peer_miso : miso_out_q;

	smp_port uut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sclk_in(sclk_w), .sclk_out_q(sclk_out_q), .sclk_oe_n_q(sclk_oe_n_q),
		.mosi_in(mosi_w), .mosi_out_q(mosi_out_q), .mosi_oe_n_q(mosi_oe_n_q),
		.miso_in(miso_w), .miso_out_q(miso_out_q), .miso_oe_n_q(miso_oe_n_q),
		.ss_n_in(ss_n_in), .port_released_q(port_released_q), .irq_q(irq_q));
	smp_peer peer (.sclk(sclk_w), .mosi(mosi_w), .ss_n(peer_ss_n),
		.miso(peer_miso), .tx_byte(peer_tx), .rx_q(peer_rx));

	// One APB transfer, result in rd and perr
	task apb(input bit w, input [7:0] a, input [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task wait_irq;
		int n;
		n = 0;
		while (irq_q !== 1'b1 && n < 300) begin
			@(posedge pclk);
			n++;
		end
	endtask

	// Master byte with a colliding write in mid-transfer
	task t_xfer(input [31:0] ctl, input [7:0] tx, pb, erx, ego);
		apb(1, `SMP_CTRL_OFS, ctl);
		`CHK("idle oe", 1'b1, mosi_oe_n_q)
		// select dropped and raised around each byte
		peer_tx <= pb;
		peer_ss_n <= 1'b0;
		apb(1, `SMP_DATA_OFS, {24'h0, tx});
		`CHK("active oe", 1'b0, mosi_oe_n_q)
		apb(1, `SMP_DATA_OFS, 32'hFF);
		wait_irq;
		`CHK("irq", 1'b1, irq_q)
		peer_ss_n <= 1'b1;
		`CHK("peer rx", erx, peer_rx)
		apb(0, `SMP_DATA_OFS, 0);
		`CHK("rx buffer", {24'h0, ego}, rd)
		apb(0, `SMP_STAT_OFS, 0);
		`CHK("status", 32'hC0, rd)
		apb(1, `SMP_STAT_OFS, 32'hC0);
		apb(0, `SMP_STAT_OFS, 0);
		`CHK("status clr", 32'h0, rd)
		`CHK("idle again", 1'b1, sclk_oe_n_q)
	endtask

	// Select pulled low while master
	task t_force;
		apb(1, `SMP_CTRL_OFS, 32'h150);
		@(posedge pclk);
		`CHK("in use", 1'b0, port_released_q)
		ss_n_in <= 1'b0;
		repeat (8) @(posedge pclk);
		`CHK("miso oe", 1'b0, miso_oe_n_q)
		`CHK("sclk oe", 1'b1, sclk_oe_n_q)
		apb(0, `SMP_CTRL_OFS, 0);
		`CHK("ctrl", 32'h140, rd)
		apb(0, `SMP_STAT_OFS, 0);
		`CHK("status", 32'h80, rd)
		// Phase 0 slave, select low: data write collides
		apb(1, `SMP_DATA_OFS, 32'h80);
		apb(0, `SMP_STAT_OFS, 0);
		`CHK("slave write_collision_flag", 32'hC0, rd)
		apb(1, `SMP_STAT_OFS, 32'hC0);
		ss_n_in <= 1'b1;
		repeat (8) @(posedge pclk);
		`CHK("miso oe off", 1'b1, miso_oe_n_q)
		apb(0, `SMP_CTRL_OFS, 0);
		`CHK("ctrl kept", 32'h140, rd)
		// Deselected slave takes its byte without collision
		apb(1, `SMP_DATA_OFS, 32'h80);
		apb(0, `SMP_STAT_OFS, 0);
		`CHK("slave load", 32'h0, rd)
		ss_n_in <= 1'b0;
		repeat (8) @(posedge pclk);
		`CHK("slave top bit", 1'b1, miso_out_q)
		`CHK("slave drives", 1'b0, miso_oe_n_q)
		ss_n_in <= 1'b1;
		repeat (8) @(posedge pclk);
		apb(1, `SMP_STAT_OFS, 32'hC0);
	endtask

	task report_and_stop;
		$display("checks %0d errors %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// Watchdog
	initial begin
		repeat (20000) @(posedge pclk);
		fails++;
		report_and_stop;
	end

	initial begin
		{presetn, psel, penable, pwrite, perr} = 5'h00;
		{ss_n_in, peer_ss_n} = 2'h3;
		{paddr, peer_tx, pwdata} = 48'h0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(0, `SMP_CTRL_OFS, 0);
		`CHK("ctrl reset", 32'h0, rd)
		`CHK("released", 1'b1, port_released_q)
		// phase 0 runs keep select-ignore clear
		t_xfer(32'h150, 8'h3C, 8'hA5, 8'h3C, 8'hA5);
		t_xfer(32'h171, 8'h01, 8'h80, 8'h80, 8'h01);
		t_force;
		apb(0, 8'h0C, 0);
		`CHK("unmapped", 1'b1, perr)
		apb(1, `SMP_CTRL_OFS, 0);
		@(posedge pclk);
		`CHK("released", 1'b1, port_released_q)
		report_and_stop;
	end
endmodule

bind smp_port smp_props u_props (.pclk(pclk), .presetn(presetn), .ce(ce),
	.psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .sclk_out_q(sclk_out_q),
	.sclk_oe_n_q(sclk_oe_n_q), .mosi_oe_n_q(mosi_oe_n_q),
	.miso_oe_n_q(miso_oe_n_q), .port_released_q(port_released_q));
